// ### thermo_pkg.sv
// Operation
// - cooling: compressor off after intake minus internal set stays below -1.5C for 3 min
// - cooling or dry: restart after 3 min wait, only above that mode's off point
// - dry: compressor off after intake minus internal set stays below -2.0C for 3 min
// - heating: compressor off after intake minus internal set stays above +2.0C for 3 min
// - heating: restart after 3 min wait, only below heating off point
// - cooling or dry, thermostat off, auto fan: indoor fan stops periodically
// - internal set starts from remote set point, shifted, recomputed continuously
// - each auto judgment runs indoor fan at lowest step for 30 s first
// - auto mode repeats its mode judgment every 10 minutes
// - first judgment: cooling when intake minus remote set is at least 2.0C
// - first judgment: dry when difference is from -2.0C up to below 2.0C
// - any judgment: heating when difference is below -2.0C
// - later judgments: at least 3.0C keeps dry if dry, else cooling
// - later judgments: -2.0C up to below 3.0C keeps previous mode
// - fan only: indoor fan runs, outdoor fan and compressor stop, setting ignored
// - forced button press or 5 s emergency hold with beep starts cooling
package thermo_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SEC_CYCLES = CLK_HZ / 1;  // clocks per one-second tick
  localparam int TICK_W = 26;
  localparam int CNT_W = 10;
  localparam int QUAL_MIN = 3;
  localparam int QUAL_S = QUAL_MIN * 60;
  localparam int RESTART_S = QUAL_MIN * 60;
  localparam int SAMPLE_S = 30;
  localparam int JUDGE_MIN = 10;
  localparam int JUDGE_S = JUDGE_MIN * 60 - SAMPLE_S;  // hold part of the interval
  localparam int EMERG_S = 5;
  localparam int FAN_PER_S = 60;
  localparam int FAN_STOP_S = 30;
  // ----------------------------------------
  // temperatures, signed, 0.5 C per lsb
  // ----------------------------------------
  localparam logic signed [8:0] COOL_OFF = -9'sh003;
  localparam logic signed [8:0] DRY_OFF = -9'sh004;
  localparam logic signed [8:0] HEAT_OFF = 9'sh004;
  localparam logic signed [8:0] AUTO_LOW = -9'sh004;
  localparam logic signed [8:0] AUTO_COOL1 = 9'sh004;
  localparam logic signed [8:0] AUTO_COOL2 = 9'sh006;
  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] SETPT_ADDR = 32'h0000_0004;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0008;
  localparam logic [31:0] SENSE_ADDR = 32'h0000_000c;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_FAN_AUTO = 4;
  localparam int CTRL_FAN = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] SETPT_RST = 16'h0032;  // 25.0 C, no shift
  localparam logic [2:0] LOWEST_FAN_STEP = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {REQ_FAN, REQ_COOL, REQ_DRY, REQ_HEAT, REQ_AUTO} req_t;
  typedef enum logic [2:0] {OP_STOP, OP_FAN, OP_COOL, OP_DRY, OP_HEAT} op_t;
  typedef enum logic [1:0] {AU_IDLE, AU_SAMPLE, AU_HOLD} auto_st_t;
  typedef struct packed {
    logic comp;
    logic outdoor_fan;
    logic indoor_fan;
    logic fan_auto;
    logic [2:0] fan_step;
  } drive_t;

  // signed difference a - b, one bit wider so it never wraps
  function automatic logic signed [8:0] tdiff(input logic signed [7:0] a,
                                              input logic signed [7:0] b);
    tdiff = 9'(a) - 9'(b);
  endfunction
endpackage

// ### tick_gen.sv
`timescale 1ns/100ps
// one-clock pulse once per second of enabled clock
module tick_gen #(
  parameter int unsigned DIV = thermo_pkg::SEC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // pulse
  output logic tick
);
  logic [thermo_pkg::TICK_W-1:0] cnt_r;

  assign tick = ce && (cnt_r == thermo_pkg::TICK_W'(DIV - 1));

  // free-running divider
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= tick ? '0 : cnt_r + 1'b1;
    end
  end
endmodule

// ### qual_timer.sv
`timescale 1ns/100ps
// counts seconds while cond holds; any gap restarts it from zero
module qual_timer #(
  parameter int unsigned LIMIT = thermo_pkg::QUAL_S
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  // condition and result
  input wire logic cond,
  output logic hit,
  output logic done
);
  logic [thermo_pkg::CNT_W-1:0] cnt_r;

  assign done = cond && (cnt_r == thermo_pkg::CNT_W'(LIMIT));
  assign hit = cond && tick && (cnt_r == thermo_pkg::CNT_W'(LIMIT - 1));

  // saturating seconds count
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (!cond) begin
        cnt_r <= '0;
      end else if (tick && !done) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// ### thermo_ctrl.sv
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module thermo_ctrl #(
  parameter int unsigned SEC_CYCLES = thermo_pkg::SEC_CYCLES
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // sensor and buttons
  input wire logic signed [7:0] intake_temp,
  input wire logic forced_btn,
  input wire logic emerg_btn,
  // drives
  output thermo_pkg::drive_t drive,
  output thermo_pkg::op_t op_mode,
  output logic beep
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0] ctrl_r;
  logic [15:0] setpt_r;
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [31:0] aw_addr_r, w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_go, ctrl_wr;
  logic signed [7:0] internal_set_r;
  logic signed [8:0] diff_int, diff_rem;
  logic forced_r, forced_btn_q, beep_r;
  logic thermo_off_r, first_r;
  thermo_pkg::op_t op_r, op_nxt, auto_mode_r, judged;
  thermo_pkg::auto_st_t au_st_r;
  thermo_pkg::req_t req;
  thermo_pkg::drive_t drive_r, drive_nxt;
  logic running, comp_mode, off_cond, on_cond, sampling;
  logic [5:0] fan_cyc_r;
  logic per_en, fan_paused;
  logic tick;
  logic off_hit, off_done, rst_done, samp_hit, judge_hit, emerg_hit;
  localparam int CTRL_MODE_HI = thermo_pkg::CTRL_MODE + 2;

  // ----------------------------------------
  // timebase and timers
  // ----------------------------------------
  tick_gen #(.DIV(SEC_CYCLES)) u_tick (
    .clk(clk), .rst(rst), .ce(ce), .tick(tick)
  );

  // switch-off qualification
  qual_timer #(.LIMIT(thermo_pkg::QUAL_S)) u_off (
    .clk(clk), .rst(rst), .ce(ce), .tick(tick),
    .cond(comp_mode && !thermo_off_r && off_cond), .hit(off_hit), .done(off_done)
  );

  // restart wait after a thermostat-off
  qual_timer #(.LIMIT(thermo_pkg::RESTART_S)) u_rst (
    .clk(clk), .rst(rst), .ce(ce), .tick(tick),
    .cond(thermo_off_r), .hit(), .done(rst_done)
  );

  // auto sampling and hold periods
  qual_timer #(.LIMIT(thermo_pkg::SAMPLE_S)) u_samp (
    .clk(clk), .rst(rst), .ce(ce), .tick(tick),
    .cond(au_st_r == thermo_pkg::AU_SAMPLE), .hit(samp_hit), .done()
  );
  qual_timer #(.LIMIT(thermo_pkg::JUDGE_S)) u_judge (
    .clk(clk), .rst(rst), .ce(ce), .tick(tick),
    .cond(au_st_r == thermo_pkg::AU_HOLD), .hit(judge_hit), .done()
  );

  // emergency button hold
  qual_timer #(.LIMIT(thermo_pkg::EMERG_S)) u_emerg (
    .clk(clk), .rst(rst), .ce(ce), .tick(tick),
    .cond(emerg_btn), .hit(emerg_hit), .done()
  );

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  // byte-lane merge for the set point; control only ever takes lane 0
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    lane_merge = old;
    if (strb[0]) lane_merge[7:0] = nw[7:0];
    if (strb[1]) lane_merge[15:8] = nw[15:8];
  endfunction

  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign ctrl_wr = wr_go && (aw_addr_r == thermo_pkg::CTRL_ADDR);
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // address and data latch in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // register writes and write response
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= thermo_pkg::CTRL_RST;
      setpt_r <= thermo_pkg::SETPT_RST;
      bvalid_r <= 1'b0;
      bresp_r <= thermo_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= thermo_pkg::RESP_OKAY;
        if (aw_addr_r == thermo_pkg::CTRL_ADDR) begin
          if (w_strb_r[0]) ctrl_r <= w_data_r[7:0];
        end else if (aw_addr_r == thermo_pkg::SETPT_ADDR) begin
          setpt_r <= lane_merge(setpt_r, w_data_r, w_strb_r);
        end else if (aw_addr_r == thermo_pkg::STATUS_ADDR ||
                     aw_addr_r == thermo_pkg::SENSE_ADDR) begin
          bresp_r <= thermo_pkg::RESP_OKAY;  // read-only, write ignored
        end else begin
          bresp_r <= thermo_pkg::RESP_SLVERR;
        end
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel, data registered at address acceptance
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= thermo_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_r <= 1'b1;
        rresp_r <= thermo_pkg::RESP_OKAY;
        if (araddr == thermo_pkg::CTRL_ADDR) begin
          rdata_r <= {24'h0, ctrl_r};
        end else if (araddr == thermo_pkg::SETPT_ADDR) begin
          rdata_r <= {16'h0, setpt_r};
        end else if (araddr == thermo_pkg::STATUS_ADDR) begin
          rdata_r <= {14'h0, first_r, au_st_r, auto_mode_r, thermo_off_r, forced_r,
                      op_r, drive_r};
        end else if (araddr == thermo_pkg::SENSE_ADDR) begin
          rdata_r <= {16'h0, internal_set_r, intake_temp};
        end else begin
          rdata_r <= '0;
          rresp_r <= thermo_pkg::RESP_SLVERR;
        end
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // set temperature and differences
  // ----------------------------------------
  // remote set point plus software shift, refreshed every cycle; no saturation
  always_ff @(posedge clk) begin
    if (rst) begin
      internal_set_r <= signed'(thermo_pkg::SETPT_RST[7:0]);
    end else if (ce) begin
      internal_set_r <= signed'(setpt_r[7:0] + setpt_r[15:8]);
    end
  end

  assign diff_int = thermo_pkg::tdiff(intake_temp, internal_set_r);
  assign diff_rem = thermo_pkg::tdiff(intake_temp, signed'(setpt_r[7:0]));

  // ----------------------------------------
  // forced cooling and emergency start
  // ----------------------------------------
  // press edge or 5 s hold latches forced cooling; a ctrl write ends it, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      forced_btn_q <= 1'b0;
      forced_r <= 1'b0;
      beep_r <= 1'b0;
    end else if (ce) begin
      forced_btn_q <= forced_btn;
      beep_r <= emerg_hit;
      if ((forced_btn && !forced_btn_q) || emerg_hit) begin
        forced_r <= 1'b1;
      end else if (ctrl_wr) begin
        forced_r <= 1'b0;
      end
    end
  end

  assign req = forced_r ? thermo_pkg::REQ_COOL
                        : thermo_pkg::req_t'(ctrl_r[CTRL_MODE_HI:thermo_pkg::CTRL_MODE]);
  assign running = ctrl_r[thermo_pkg::CTRL_RUN] || forced_r;
  assign beep = beep_r;

  // ----------------------------------------
  // automatic mode judgment
  // ----------------------------------------
  // heat below -2.0; first: cool at 2.0; later: cool at 3.0 unless dry, else hold
  always_comb begin
    if (diff_rem < thermo_pkg::AUTO_LOW) begin
      judged = thermo_pkg::OP_HEAT;
    end else if (first_r) begin
      judged = (diff_rem >= thermo_pkg::AUTO_COOL1) ? thermo_pkg::OP_COOL
                                                    : thermo_pkg::OP_DRY;
    end else if (diff_rem >= thermo_pkg::AUTO_COOL2) begin
      judged = (auto_mode_r == thermo_pkg::OP_DRY) ? thermo_pkg::OP_DRY
                                                   : thermo_pkg::OP_COOL;
    end else begin
      judged = auto_mode_r;
    end
  end

  // sample 30 s, decide, hold the rest of the 10 min interval, sample again
  always_ff @(posedge clk) begin
    if (rst) begin
      au_st_r <= thermo_pkg::AU_IDLE;
      first_r <= 1'b1;
      auto_mode_r <= thermo_pkg::OP_FAN;
    end else if (ce) begin
      if (!running || req != thermo_pkg::REQ_AUTO) begin
        au_st_r <= thermo_pkg::AU_IDLE;
        first_r <= 1'b1;
        auto_mode_r <= thermo_pkg::OP_FAN;
      end else begin
        case (au_st_r)
          thermo_pkg::AU_IDLE: begin
            au_st_r <= thermo_pkg::AU_SAMPLE;
          end
          thermo_pkg::AU_SAMPLE: begin
            if (samp_hit) begin
              auto_mode_r <= judged;
              first_r <= 1'b0;
              au_st_r <= thermo_pkg::AU_HOLD;
            end
          end
          thermo_pkg::AU_HOLD: begin
            if (judge_hit) au_st_r <= thermo_pkg::AU_SAMPLE;
          end
          default: au_st_r <= thermo_pkg::AU_IDLE;
        endcase
      end
    end
  end

  assign sampling = (au_st_r == thermo_pkg::AU_SAMPLE);

  // ----------------------------------------
  // operating mode
  // ----------------------------------------
  always_comb begin
    op_nxt = thermo_pkg::OP_STOP;
    if (running) begin
      case (req)
        thermo_pkg::REQ_FAN: op_nxt = thermo_pkg::OP_FAN;
        thermo_pkg::REQ_COOL: op_nxt = thermo_pkg::OP_COOL;
        thermo_pkg::REQ_DRY: op_nxt = thermo_pkg::OP_DRY;
        thermo_pkg::REQ_HEAT: op_nxt = thermo_pkg::OP_HEAT;
        thermo_pkg::REQ_AUTO: op_nxt = sampling ? thermo_pkg::OP_FAN : auto_mode_r;
        default: op_nxt = thermo_pkg::OP_STOP;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_r <= thermo_pkg::OP_STOP;
    end else if (ce) begin
      op_r <= op_nxt;
    end
  end

  assign op_mode = op_r;

  // ----------------------------------------
  // thermostat
  // ----------------------------------------
  assign comp_mode = (op_r == thermo_pkg::OP_COOL) || (op_r == thermo_pkg::OP_DRY) ||
                     (op_r == thermo_pkg::OP_HEAT);

  // off and restart points per mode; restart must cross the off point back
  always_comb begin
    off_cond = 1'b0;
    on_cond = 1'b0;
    case (op_r)
      thermo_pkg::OP_COOL: begin
        off_cond = diff_int < thermo_pkg::COOL_OFF;
        on_cond = diff_int > thermo_pkg::COOL_OFF;
      end
      thermo_pkg::OP_DRY: begin
        off_cond = diff_int < thermo_pkg::DRY_OFF;
        on_cond = diff_int > thermo_pkg::DRY_OFF;
      end
      thermo_pkg::OP_HEAT: begin
        off_cond = diff_int > thermo_pkg::HEAT_OFF;
        on_cond = diff_int < thermo_pkg::HEAT_OFF;
      end
      default: begin
        off_cond = 1'b0;
        on_cond = 1'b0;
      end
    endcase
  end

  // a mode change starts the compressor afresh
  always_ff @(posedge clk) begin
    if (rst) begin
      thermo_off_r <= 1'b0;
    end else if (ce) begin
      if (op_nxt != op_r) begin
        thermo_off_r <= 1'b0;
      end else if (off_done) begin
        thermo_off_r <= 1'b1;
      end else if (thermo_off_r && rst_done && on_cond) begin
        thermo_off_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // fans and compressor
  // ----------------------------------------
  assign per_en = thermo_off_r && ctrl_r[thermo_pkg::CTRL_FAN_AUTO] &&
                  ((op_r == thermo_pkg::OP_COOL) || (op_r == thermo_pkg::OP_DRY));
  assign fan_paused = per_en && (fan_cyc_r < 6'(thermo_pkg::FAN_STOP_S));

  // stop-then-run cycle while idling on thermostat with auto fan
  always_ff @(posedge clk) begin
    if (rst) begin
      fan_cyc_r <= '0;
    end else if (ce) begin
      if (!per_en) begin
        fan_cyc_r <= '0;
      end else if (tick) begin
        fan_cyc_r <= (fan_cyc_r == 6'(thermo_pkg::FAN_PER_S - 1)) ? '0
                                                                  : fan_cyc_r + 1'b1;
      end
    end
  end

  // fan mode keeps compressor and outdoor fan off, temperature not looked at
  always_comb begin
    drive_nxt.comp = comp_mode && !thermo_off_r && (op_nxt == op_r);
    drive_nxt.outdoor_fan = drive_nxt.comp;
    drive_nxt.indoor_fan = (op_r != thermo_pkg::OP_STOP) && !fan_paused;
    drive_nxt.fan_auto = ctrl_r[thermo_pkg::CTRL_FAN_AUTO] && !sampling;
    drive_nxt.fan_step = ctrl_r[thermo_pkg::CTRL_FAN+:3];
    if (sampling) begin
      drive_nxt.fan_step = thermo_pkg::LOWEST_FAN_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_r <= '0;
    end else if (ce) begin
      drive_r <= drive_nxt;
    end
  end

  assign drive = drive_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_judge;
    sampling && samp_hit && running && req == thermo_pkg::REQ_AUTO;
  endsequence

  sequence s_off_rise;
    $rose(thermo_off_r) && $stable(op_r);
  endsequence

  a_cool_off_point: assert property (
    s_off_rise and (op_r == thermo_pkg::OP_COOL) |-> $past(diff_int) < thermo_pkg::COOL_OFF)
    else $error("cooling switched off above its off point");
  a_dry_off_point: assert property (
    s_off_rise and (op_r == thermo_pkg::OP_DRY) |-> $past(diff_int) < thermo_pkg::DRY_OFF)
    else $error("dry switched off above its off point");
  a_heat_off_point: assert property (
    s_off_rise and (op_r == thermo_pkg::OP_HEAT) |-> $past(diff_int) > thermo_pkg::HEAT_OFF)
    else $error("heating switched off below its off point");
  a_restart_wait: assert property (
    $fell(thermo_off_r) && $stable(op_r) |-> $past(rst_done) && $past(on_cond))
    else $error("compressor restarted early");
  a_heat_restart: assert property (
    $fell(thermo_off_r) && $stable(op_r) && op_r == thermo_pkg::OP_HEAT
    |-> $past(diff_int) < thermo_pkg::HEAT_OFF)
    else $error("heating restarted above off point");
  a_fan_periodic: assert property (
    per_en && fan_cyc_r == 6'h00 |=> !drive.indoor_fan)
    else $error("fan not stopped in idle cycle");
  a_sample_low_fan: assert property (
    sampling && running |=> drive.fan_step == thermo_pkg::LOWEST_FAN_STEP && !drive.comp)
    else $error("sampling not at lowest fan step");
  a_judge_heat: assert property (
    s_judge and (diff_rem < thermo_pkg::AUTO_LOW) |=> auto_mode_r == thermo_pkg::OP_HEAT)
    else $error("heating not chosen");
  a_first_dry: assert property (
    s_judge and first_r and (diff_rem >= thermo_pkg::AUTO_LOW) and
    (diff_rem < thermo_pkg::AUTO_COOL1) |=> auto_mode_r == thermo_pkg::OP_DRY)
    else $error("first judgment missed dry");
  a_later_keep: assert property (
    s_judge and !first_r and (diff_rem >= thermo_pkg::AUTO_LOW) and
    (diff_rem < thermo_pkg::AUTO_COOL2) |=> $stable(auto_mode_r))
    else $error("later judgment changed mode");
  a_fan_only: assert property (
    op_r == thermo_pkg::OP_FAN |-> !drive.comp && !drive.outdoor_fan)
    else $error("compressor ran in fan mode");
  a_emerg_start: assert property (
    emerg_hit |=> beep && forced_r ##1 op_r == thermo_pkg::OP_COOL)
    else $error("emergency hold did not start cooling");
endmodule

// ### room_model.sv
`timescale 1ns/100ps
// ------------------------------
// far side: intake sensor and buttons
// ------------------------------
module room_model (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic signed [7:0] room,
  input wire logic press,
  input wire logic hold,
  // toward the block
  output logic signed [7:0] intake_temp,
  output logic forced_btn,
  output logic emerg_btn
);
  logic [1:0] push_r = 2'h0;
  // a press lasts a few clocks, as a real contact would, never just one
  always_ff @(posedge clk) begin
    intake_temp <= room;
    push_r <= press ? 2'h3 : push_r >> 1;
    forced_btn <= push_r[0];
    emerg_btn <= hold;
  end
endmodule

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk, rst, ce, awvalid, wvalid, bready, arvalid, rready, press, hold;
  logic awready, wready, bvalid, arready, rvalid, beep, forced_btn, emerg_btn;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic signed [7:0] room, intake_temp;
  thermo_pkg::drive_t drive;
  thermo_pkg::op_t op_mode;
  logic [33:0] q[$];
  logic [33:0] e;
  int err_count, n_tests, beeps, i, rn;
  event look;
  localparam int SEC = 10;
  logic [7:0] ctl[3] = '{8'h13, 8'h15, 8'h17};
  thermo_pkg::op_t opt[3] = '{thermo_pkg::OP_COOL, thermo_pkg::OP_DRY, thermo_pkg::OP_HEAT};
  logic signed [8:0] thr[3] = '{thermo_pkg::COOL_OFF, thermo_pkg::DRY_OFF, thermo_pkg::HEAT_OFF};
  int sg[3] = '{-1, -1, 1};
  // auto fan idling on thermostat: cool and dry pause the indoor fan, heat keeps it
  logic [6:0] idl[3] = '{7'h08, 7'h08, 7'h18};
  int dd[4] = '{4, 3, -4, -5};
  thermo_pkg::op_t ao[4] = '{thermo_pkg::OP_COOL, thermo_pkg::OP_DRY, thermo_pkg::OP_DRY,
    thermo_pkg::OP_HEAT};
  thermo_ctrl #(.SEC_CYCLES(SEC)) i_thermo_ctrl (.clk, .rst, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .intake_temp, .forced_btn, .emerg_btn, .drive, .op_mode,
    .beep);
  room_model i_room_model (.clk, .room, .press, .hold, .intake_temp, .forced_btn, .emerg_btn);
  // ------------------------------
  // clock, checking and closing
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(logic [33:0] seen, logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bound(int k);
    if (k == 50) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic secs(int n);
    repeat (n * SEC) @(posedge clk);
  endtask
  // full compares the whole drive, otherwise only compressor and outdoor fan
  task automatic expect_st(thermo_pkg::op_t op, logic [6:0] dv, logic full);
    @(negedge clk);
    q.push_back({full, 23'h0, op, dv});
    ->look;
    @(posedge clk);
  endtask
  // monitors take the oldest note whenever a result shows
  always @(look) begin
    e = q.pop_front();
    check({e[33], 23'h0, op_mode, e[33] ? 7'(drive) : {drive[6:5], 5'h0}}, e);
  end
  always @(posedge clk) if (rvalid && rready) check({rresp, rdata}, q.pop_front());
  always @(posedge clk) if (beep === 1'b1) beeps++;
  // ------------------------------
  // register bus master
  // ------------------------------
  task automatic wr(logic [31:0] a, logic [31:0] d);
    int k;
    logic at, wt, bt;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (k = 0; k < 50; k++) begin
      @(negedge clk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      @(posedge clk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) break;
    end
    bready <= 1'b0;
    bound(k);
  endtask
  task automatic rd(logic [31:0] a, logic [33:0] exp);
    int k;
    logic at, rt;
    q.push_back(exp);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (k = 0; k < 50; k++) begin
      @(negedge clk);
      at = arvalid && arready;
      rt = rvalid;
      @(posedge clk);
      if (at) arvalid <= 1'b0;
      if (rt) break;
    end
    rready <= 1'b0;
    bound(k);
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {ce, rst, wstrb} = 6'h3f;
    {awvalid, wvalid, bready, arvalid, rready, press, hold} = '0;
    {awaddr, wdata, araddr} = '0;
    room = 8'sd50;
    void'($urandom(32'hca8d));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    expect_st(thermo_pkg::OP_STOP, 7'h00, 1'b1);
    rd(thermo_pkg::SETPT_ADDR, {thermo_pkg::RESP_OKAY, 16'h0, thermo_pkg::SETPT_RST});
    rd(32'h10, {thermo_pkg::RESP_SLVERR, 32'h0});
    wr(thermo_pkg::SETPT_ADDR, 32'h0232);
    rd(thermo_pkg::SENSE_ADDR, {thermo_pkg::RESP_OKAY, 32'h3432});
    wr(thermo_pkg::SETPT_ADDR, 32'h0032);
    // off point is crossed by a random margin, restart probed right at it
    for (i = 0; i < 3; i++) begin
      rn = 1 + $urandom_range(2);
      wr(32'h0, {24'h0, ctl[i]});
      secs(3);
      expect_st(opt[i], 7'h60, 1'b0);
      room <= 8'(50 + int'(thr[i]) + sg[i] * rn);
      secs(150);
      room <= 8'sd50;
      secs(5);
      room <= 8'(50 + int'(thr[i]) + sg[i] * rn);
      secs(170);
      expect_st(opt[i], 7'h60, 1'b0);
      secs(15);
      expect_st(opt[i], idl[i], 1'b1);
      room <= 8'(50 + int'(thr[i]));
      secs(190);
      expect_st(opt[i], 7'h00, 1'b0);
      room <= 8'sd50;
      secs(2);
      expect_st(opt[i], 7'h60, 1'b0);
    end
    wr(32'h0, 32'h01);
    room <= 8'($urandom_range(90));
    secs(3);
    expect_st(thermo_pkg::OP_FAN, 7'h10, 1'b1);
    for (i = 0; i < 4; i++) begin
      wr(32'h0, 32'h0);
      room <= 8'(50 + dd[i]);
      wr(32'h0, 32'h69);
      secs(10);
      expect_st(thermo_pkg::OP_FAN, 7'h10, 1'b1);
      secs(25);
      expect_st(ao[i], 7'h60, 1'b0);
    end
    room <= 8'sd56;
    secs(580);
    expect_st(thermo_pkg::OP_FAN, 7'h10, 1'b1);
    secs(25);
    expect_st(thermo_pkg::OP_COOL, 7'h60, 1'b0);
    room <= 8'sd52;
    secs(600);
    expect_st(thermo_pkg::OP_COOL, 7'h60, 1'b0);
    wr(32'h0, 32'h0);
    room <= 8'sd54;
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    secs(2);
    expect_st(thermo_pkg::OP_COOL, 7'h60, 1'b0);
    wr(32'h0, 32'h0);
    hold <= 1'b1;
    secs(6);
    hold <= 1'b0;
    secs(1);
    check(34'(beeps), 34'h1);
    expect_st(thermo_pkg::OP_COOL, 7'h60, 1'b0);
    tally_and_finish();
  end
endmodule
